// ===== inc/bsw_pkg.sv
// Purpose: Shared constants and carriers for the battery switchover block
// Assumes: 100 MHz core clock, 8-bit special function register port
// Notes: Bit positions of flags, enables and pin fields are fixed here
package bsw_pkg;
  // Special function register addresses
  localparam logic [7:0] BSW_ADDR_CORE_EN = 8'hA9;
  localparam logic [7:0] BSW_ADDR_ADC_START = 8'hD8;
  localparam logic [7:0] BSW_ADDR_BAT_ADC = 8'hDF;
  localparam logic [7:0] BSW_ADDR_IRQ_EN = 8'hEC;
  localparam logic [7:0] BSW_ADDR_DELTA = 8'hF3;
  localparam logic [7:0] BSW_ADDR_PER_CFG = 8'hF4;
  localparam logic [7:0] BSW_ADDR_SWO_CFG = 8'hF5;
  localparam logic [7:0] BSW_ADDR_FLAGS = 8'hF8;
  localparam logic [7:0] BSW_ADDR_BAT_TH = 8'hFA;
  localparam logic [7:0] BSW_ADDR_PIN_CFG = 8'hFF;
  // Flag and enable bit positions, shared by both registers
  localparam int BSW_B_DCIN_ADC = 0;
  localparam int BSW_B_BAT = 1;
  localparam int BSW_B_SWO = 2;
  localparam int BSW_B_RESTORE = 3;
  localparam int BSW_B_DCIN_LOW = 4;
  localparam int BSW_B_SAG = 5;
  localparam logic [7:0] BSW_FLAG_MASK = 8'h3F;
  // Other fields
  localparam int BSW_B_MON_IRQ_EN = 1;
  localparam int BSW_B_RAIL_SRC = 6;
  localparam int BSW_PIN_LO = 4;
  localparam logic [1:0] BSW_PIN_BAT_CTRL = 2'h1;
  localparam logic [1:0] BSW_SEL_MAIN = 2'h0;
  localparam logic [1:0] BSW_SEL_DCIN = 2'h1;
  // Reset values
  localparam logic [7:0] BSW_RST_ZERO = 8'h00;
  localparam logic [7:0] BSW_RST_PER_CFG = 8'h40;
  // Timing
  localparam int BSW_CLK_PERIOD_NS = 10;
  localparam int BSW_DCIN_DELAY_MS = 30;
  localparam int BSW_RESTORE_DELAY_MS = 130;
  localparam int BSW_BG_PERIOD_MS = 10;
  localparam int BSW_DCIN_DELAY_CYC = BSW_DCIN_DELAY_MS * 1000000 / BSW_CLK_PERIOD_NS;
  localparam int BSW_RESTORE_DELAY_CYC = BSW_RESTORE_DELAY_MS * 1000000 / BSW_CLK_PERIOD_NS;
  localparam int BSW_BG_PERIOD_CYC = BSW_BG_PERIOD_MS * 1000000 / BSW_CLK_PERIOD_NS;
  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bsw_sfr_req_t;
  // Comparator and pin levels, asynchronous to clk
  typedef struct packed {
    logic vdd_ok;
    logic dcin_ok;
    logic bat_ctrl;
  } bsw_cmp_t;
  // Rail selection states, Gray along main, wait, battery, restore
  typedef enum logic [1:0] {
    BSW_ON_MAIN = 2'h0,
    BSW_DCIN_WAIT = 2'h1,
    BSW_ON_BAT = 2'h3,
    BSW_RESTORE_WAIT = 2'h2
  } bsw_state_t;
endpackage : bsw_pkg

// ===== hdl/bsw_switchover.sv
// Purpose: Rail source selection and power monitor event flags
// Assumes: Comparators asynchronous, ADC and sag pulses on clk
// Notes: Long delays are parameters so simulation can shorten them
// Contract
// - Selection 01 and low DC input selects battery
// - Selection 00 and low main selects battery
// - Enabled control pin falling edge selects battery
// - Restore only when all enabled conditions hold
// - Selection 01 restore also needs DC input
// - Enabled control pin must be high to restore
// - Restore waits 130 ms after conditions hold
// - DC input switchover waits 30 ms
// - Monitor interrupt masked until core enable set
// - Flags latched, software clears via flag register
// - Main to battery sets switchover flag
// - Battery to main sets restored flag
// - Flags set regardless, cleared by writing zero
// - Config bit 6 shows main rail source
// - ADC ready sets DC input ADC flag
// - Periodic and on demand DC input conversions
// - Low battery or new measurement sets flag
// - DC input below threshold sets low flag
// - Sag event from metering sets sag flag
`timescale 1ns/10ps
module bsw_switchover import bsw_pkg::*; #(
  parameter logic [23:0] DCIN_WAIT_CYC = 24'(BSW_DCIN_DELAY_CYC),
  parameter logic [23:0] RESTORE_WAIT_CYC = 24'(BSW_RESTORE_DELAY_CYC),
  parameter logic [23:0] BG_PERIOD_CYC = 24'(BSW_BG_PERIOD_CYC)
) (
  input wire logic clk,
  input wire logic resetn,
  input wire bsw_sfr_req_t sfr,
  input wire bsw_cmp_t cmp,
  input wire logic sag_event,
  input wire logic bat_adc_ready,
  input wire logic [7:0] bat_adc_data,
  input wire logic dcin_adc_ready,
  output logic [7:0] sfr_rdata,
  output logic rail_on_main,
  output logic dcin_adc_convert,
  output logic mon_irq
);
  // Synchroniser chains, one lane per level
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  // Filtered levels: vdd_ok, dcin_ok, bat_ctrl
  logic [2:0] lvl;
  logic bat_ctrl_fall;
  // Software visible registers
  logic [7:0] core_irq_enable_priority_two;
  logic [7:0] adc_start;
  logic [7:0] battery_adc_value;
  logic [7:0] monitor_irq_enable;
  logic [7:0] temp_supply_delta;
  logic [7:0] peripheral_config;
  logic [7:0] switchover_config;
  logic [7:0] monitor_irq_flags;
  logic [7:0] battery_threshold;
  logic [7:0] irq_pin_config;
  // Selection machine
  bsw_state_t state;
  bsw_state_t next_state;
  logic [23:0] wait_cnt;
  logic [23:0] bg_cnt;
  logic to_bat;
  logic to_main;
  logic [7:0] flag_set;
  // Decoded controls
  logic [1:0] switchover_source_sel;
  logic pin_en;
  logic vdd_ok;
  logic dcin_ok;
  logic bat_ctrl_high;
  logic fast_trip;
  logic restore_ok;

  // Register write strobe for one address
  function automatic logic sfr_hit(input bsw_sfr_req_t r, input logic [7:0] a);
    sfr_hit = r.wr && (r.addr == a);
  endfunction : sfr_hit

  // Levels come in three flops; a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
        end else begin
          sync1[gi] <= cmp[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
        end
      end
      // Level filter; reset to the safe "supply bad, pin low" view
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          lvl[gi] <= 1'b0;
        end else if (sync2[gi] == sync3[gi]) begin
          lvl[gi] <= sync3[gi];
        end
      end
    end
  endgenerate

  assign bat_ctrl_high = lvl[0];
  assign dcin_ok = lvl[1];
  assign vdd_ok = lvl[2];
  // Edge seen when filtered pin high and agreed samples now low
  assign bat_ctrl_fall = lvl[0] && (sync2[0] == sync3[0]) && !sync3[0];

  // Control fields
  assign switchover_source_sel = switchover_config[1:0];
  assign pin_en = irq_pin_config[BSW_PIN_LO +: 2] == BSW_PIN_BAT_CTRL;
  // Immediate trips from main supply or control pin
  assign fast_trip = ((switchover_source_sel == BSW_SEL_MAIN) && !vdd_ok)
    || (pin_en && bat_ctrl_fall);
  // All enabled restore conditions together
  assign restore_ok = vdd_ok
    && ((switchover_source_sel != BSW_SEL_DCIN) || dcin_ok)
    && (!pin_en || bat_ctrl_high);

  // Next rail state
  always_comb begin
    next_state = state;
    case (state)
      BSW_ON_MAIN: begin
        if (fast_trip) begin
          next_state = BSW_ON_BAT;
        end else if ((switchover_source_sel == BSW_SEL_DCIN) && !dcin_ok) begin
          next_state = BSW_DCIN_WAIT;
        end
      end
      BSW_DCIN_WAIT: begin
        if (fast_trip) begin
          next_state = BSW_ON_BAT;
        end else if ((switchover_source_sel != BSW_SEL_DCIN) || dcin_ok) begin
          next_state = BSW_ON_MAIN; // Glitch shorter than the delay
        end else if (wait_cnt == DCIN_WAIT_CYC - 24'h1) begin
          next_state = BSW_ON_BAT;
        end
      end
      BSW_ON_BAT: begin
        if (restore_ok) begin
          next_state = BSW_RESTORE_WAIT;
        end
      end
      BSW_RESTORE_WAIT: begin
        if (!restore_ok) begin
          next_state = BSW_ON_BAT; // Conditions must stay true
        end else if (wait_cnt == RESTORE_WAIT_CYC - 24'h1) begin
          next_state = BSW_ON_MAIN;
        end
      end
      default: begin
        next_state = BSW_ON_BAT;
      end
    endcase
  end

  // Transitions of the real rail source
  assign to_bat = rail_on_main && !((next_state == BSW_ON_MAIN)
    || (next_state == BSW_DCIN_WAIT));
  assign to_main = !rail_on_main && (next_state == BSW_ON_MAIN);

  // State register; reset starts on battery and waits for a good main
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= BSW_ON_BAT;
    end else begin
      state <= next_state;
    end
  end

  // Shared delay counter, cleared on every state change
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_cnt <= 24'h0;
    end else if (next_state != state) begin
      wait_cnt <= 24'h0;
    end else if ((state == BSW_DCIN_WAIT) || (state == BSW_RESTORE_WAIT)) begin
      wait_cnt <= wait_cnt + 24'h1;
    end
  end

  // Rail source output, main during main and the DC input grace period
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rail_on_main <= 1'b0;
    end else begin
      rail_on_main <= (next_state == BSW_ON_MAIN) || (next_state == BSW_DCIN_WAIT);
    end
  end

  // Background conversion timer plus on demand start
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bg_cnt <= 24'h0;
      dcin_adc_convert <= 1'b0;
    end else begin
      bg_cnt <= (bg_cnt == BG_PERIOD_CYC - 24'h1) ? 24'h0 : bg_cnt + 24'h1;
      dcin_adc_convert <= (bg_cnt == BG_PERIOD_CYC - 24'h1)
        || sfr_hit(sfr, BSW_ADDR_ADC_START);
    end
  end

  // Plain read-write registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      core_irq_enable_priority_two <= BSW_RST_ZERO;
      adc_start <= BSW_RST_ZERO;
      monitor_irq_enable <= BSW_RST_ZERO;
      temp_supply_delta <= BSW_RST_ZERO;
      switchover_config <= BSW_RST_ZERO;
      battery_threshold <= BSW_RST_ZERO;
      irq_pin_config <= BSW_RST_ZERO;
    end else begin
      if (sfr_hit(sfr, BSW_ADDR_CORE_EN)) core_irq_enable_priority_two <= sfr.wdata;
      if (sfr_hit(sfr, BSW_ADDR_ADC_START)) adc_start <= sfr.wdata;
      if (sfr_hit(sfr, BSW_ADDR_IRQ_EN)) monitor_irq_enable <= sfr.wdata;
      if (sfr_hit(sfr, BSW_ADDR_DELTA)) temp_supply_delta <= sfr.wdata;
      if (sfr_hit(sfr, BSW_ADDR_SWO_CFG)) switchover_config <= sfr.wdata;
      if (sfr_hit(sfr, BSW_ADDR_BAT_TH)) battery_threshold <= sfr.wdata;
      if (sfr_hit(sfr, BSW_ADDR_PIN_CFG)) irq_pin_config <= sfr.wdata;
    end
  end

  // Peripheral config: bit 6 tracks the rail, the rest is storage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      peripheral_config <= BSW_RST_ZERO;
    end else begin
      if (sfr_hit(sfr, BSW_ADDR_PER_CFG)) peripheral_config <= sfr.wdata;
      peripheral_config[BSW_B_RAIL_SRC] <= rail_on_main;
    end
  end

  // Battery sample capture
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      battery_adc_value <= BSW_RST_ZERO;
    end else if (bat_adc_ready) begin
      battery_adc_value <= bat_adc_data;
    end
  end

  // Event sources for the sticky flags
  always_comb begin
    flag_set = 8'h00;
    flag_set[BSW_B_DCIN_ADC] = dcin_adc_ready;
    flag_set[BSW_B_BAT] = bat_adc_ready || (battery_adc_value < battery_threshold);
    flag_set[BSW_B_SWO] = to_bat;
    flag_set[BSW_B_RESTORE] = to_main;
    flag_set[BSW_B_DCIN_LOW] = !dcin_ok;
    flag_set[BSW_B_SAG] = sag_event;
  end

  // Sticky flags; written zeros clear, a same-cycle event still wins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      monitor_irq_flags <= BSW_RST_ZERO;
    end else if (sfr_hit(sfr, BSW_ADDR_FLAGS)) begin
      monitor_irq_flags <= ((monitor_irq_flags & sfr.wdata) | flag_set) & BSW_FLAG_MASK;
    end else begin
      monitor_irq_flags <= monitor_irq_flags | flag_set;
    end
  end

  // One shared request, registered to keep the output glitch free
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mon_irq <= 1'b0;
    end else begin
      mon_irq <= core_irq_enable_priority_two[BSW_B_MON_IRQ_EN]
        && |(monitor_irq_flags & monitor_irq_enable & BSW_FLAG_MASK);
    end
  end

  // Registered read data; unmapped addresses read zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sfr_rdata <= 8'h00;
    end else if (sfr.rd) begin
      case (sfr.addr)
        BSW_ADDR_CORE_EN: sfr_rdata <= core_irq_enable_priority_two;
        BSW_ADDR_ADC_START: sfr_rdata <= adc_start;
        BSW_ADDR_BAT_ADC: sfr_rdata <= battery_adc_value;
        BSW_ADDR_IRQ_EN: sfr_rdata <= monitor_irq_enable;
        BSW_ADDR_DELTA: sfr_rdata <= temp_supply_delta;
        BSW_ADDR_PER_CFG: sfr_rdata <= peripheral_config;
        BSW_ADDR_SWO_CFG: sfr_rdata <= switchover_config;
        BSW_ADDR_FLAGS: sfr_rdata <= monitor_irq_flags;
        BSW_ADDR_BAT_TH: sfr_rdata <= battery_threshold;
        BSW_ADDR_PIN_CFG: sfr_rdata <= irq_pin_config;
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end

  // Checks on the selection and flag logic
  AST_VDD_LOW: assert property (@(posedge clk) disable iff (!resetn)
    rail_on_main && switchover_source_sel == BSW_SEL_MAIN && !vdd_ok |=> !rail_on_main)
    else $error("low main supply did not select battery");
  AST_PIN_FALL: assert property (@(posedge clk) disable iff (!resetn)
    rail_on_main && pin_en && bat_ctrl_fall |=> !rail_on_main)
    else $error("control pin edge did not select battery");
  AST_DCIN_ENTER: assert property (@(posedge clk) disable iff (!resetn)
    state == BSW_ON_MAIN && switchover_source_sel == BSW_SEL_DCIN && !dcin_ok
    |=> state != BSW_ON_MAIN)
    else $error("low DC input ignored");
  AST_DCIN_DELAY: assert property (@(posedge clk) disable iff (!resetn)
    $fell(rail_on_main) && $past(state) == BSW_DCIN_WAIT && !$past(fast_trip)
    |-> $past(wait_cnt) == DCIN_WAIT_CYC - 24'h1)
    else $error("DC input switchover delay wrong");
  AST_NO_EARLY: assert property (@(posedge clk) disable iff (!resetn)
    !rail_on_main && !restore_ok |=> !rail_on_main)
    else $error("restored without conditions");
  AST_SEL_DCIN: assert property (@(posedge clk) disable iff (!resetn)
    !rail_on_main && switchover_source_sel == BSW_SEL_DCIN && !dcin_ok |=> !rail_on_main)
    else $error("restored with low DC input");
  AST_PIN_HOLD: assert property (@(posedge clk) disable iff (!resetn)
    !rail_on_main && pin_en && !bat_ctrl_high |=> !rail_on_main)
    else $error("restored with control pin low");
  AST_RESTORE_DELAY: assert property (@(posedge clk) disable iff (!resetn)
    $rose(rail_on_main) |-> $past(state) == BSW_RESTORE_WAIT
    && $past(wait_cnt) == RESTORE_WAIT_CYC - 24'h1)
    else $error("restore delay wrong");
  AST_IRQ_MASK: assert property (@(posedge clk) disable iff (!resetn)
    !core_irq_enable_priority_two[BSW_B_MON_IRQ_EN] |=> !mon_irq)
    else $error("interrupt while masked");
  AST_SWO_FLAG: assert property (@(posedge clk) disable iff (!resetn)
    $fell(rail_on_main) |-> monitor_irq_flags[BSW_B_SWO])
    else $error("switchover flag missing");
  AST_RESTORE_FLAG: assert property (@(posedge clk) disable iff (!resetn)
    $rose(rail_on_main) |-> monitor_irq_flags[BSW_B_RESTORE])
    else $error("restored flag missing");
  AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (!resetn)
    monitor_irq_flags[BSW_B_SWO] && !(sfr_hit(sfr, BSW_ADDR_FLAGS) && !sfr.wdata[BSW_B_SWO])
    |=> monitor_irq_flags[BSW_B_SWO])
    else $error("flag lost without clear");
  AST_STATUS: assert property (@(posedge clk) disable iff (!resetn)
    sfr.rd && sfr.addr == BSW_ADDR_PER_CFG ##1 $stable(rail_on_main)
    |-> sfr_rdata[BSW_B_RAIL_SRC] == $past(rail_on_main, 2))
    else $error("rail source bit wrong");
  AST_IRQ_OR: assert property (@(posedge clk) disable iff (!resetn)
    core_irq_enable_priority_two[BSW_B_MON_IRQ_EN] && monitor_irq_flags[BSW_B_SWO]
    && monitor_irq_enable[BSW_B_SWO] |=> mon_irq)
    else $error("enabled flag gave no interrupt");
  // Event flags must latch the cycle after their source; set wins over a clear
  AST_DCIN_LOW_FLAG: assert property (@(posedge clk) disable iff (!resetn)
    !dcin_ok |=> monitor_irq_flags[BSW_B_DCIN_LOW])
    else $error("low DC input flag missing");
  AST_SAG_FLAG: assert property (@(posedge clk) disable iff (!resetn)
    sag_event |=> monitor_irq_flags[BSW_B_SAG])
    else $error("sag flag missing");
  AST_ADC_FLAG: assert property (@(posedge clk) disable iff (!resetn)
    dcin_adc_ready |=> monitor_irq_flags[BSW_B_DCIN_ADC])
    else $error("DC input sample flag missing");
  AST_BAT_FLAG: assert property (@(posedge clk) disable iff (!resetn)
    bat_adc_ready |=> monitor_irq_flags[BSW_B_BAT])
    else $error("battery sample flag missing");
  // A start write must launch a conversion on the very next cycle
  AST_CONV_START: assert property (@(posedge clk) disable iff (!resetn)
    sfr_hit(sfr, BSW_ADDR_ADC_START) |=> dcin_adc_convert)
    else $error("start write gave no conversion");
  COV_TO_BAT: cover property (@(posedge clk) disable iff (!resetn) $fell(rail_on_main));
  COV_TO_MAIN: cover property (@(posedge clk) disable iff (!resetn) $rose(rail_on_main));
  COV_DCIN_WAIT: cover property (@(posedge clk) disable iff (!resetn)
    state == BSW_DCIN_WAIT ##1 state == BSW_ON_BAT);
  COV_IRQ: cover property (@(posedge clk) disable iff (!resetn) $rose(mon_irq));
  COV_FLAG_CLEAR: cover property (@(posedge clk) disable iff (!resetn)
    sfr_hit(sfr, BSW_ADDR_FLAGS) ##1 monitor_irq_flags == 8'h00);
endmodule : bsw_switchover

// ===== verification/bsw_core_model.sv
// Purpose: Processor core side of the special function register port
// Assumes: One access at a time, requests launched just after a rising edge
// Notes: Read data is taken one edge after the strobe edge, where it stands
`timescale 1ns/10ps
module bsw_core_model import bsw_pkg::*; (
  input wire logic clk,
  output bsw_sfr_req_t sfr,
  input wire logic [7:0] sfr_rdata,
  input wire logic mon_irq
);
  // Interrupt requests seen, checked by the bench at the end
  int irq_rises = 0;
  logic irq_prev = 1'b0;

  // Bus idle from time zero
  initial begin
    sfr = '0;
  end

  // Count interrupt assertions as the core would see them
  always @(posedge clk) begin
    irq_prev <= mon_irq;
    if (mon_irq === 1'b1 && irq_prev !== 1'b1) irq_rises <= irq_rises + 1;
  end

  // Single-cycle write; flag clearing is done through this path too
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    @(posedge clk);
    sfr <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: dt};
    @(posedge clk);
    sfr.wr <= 1'b0;
  endtask : wr

  // Single-cycle read; sampled one edge later to stay clear of the update
  task automatic rd(input logic [7:0] ad, output logic [7:0] dt);
    @(posedge clk);
    sfr <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 8'h00};
    @(posedge clk);
    sfr.rd <= 1'b0;
    @(posedge clk);
    #1;
    dt = sfr_rdata;
  endtask : rd
endmodule : bsw_core_model

// ===== verification/tb_top.sv
// Purpose: Self-checking bench for rail source selection and monitor flags
// Assumes: Shortened delays of 20, 40 and 50 cycles for the long counts
// Notes: Expected register contents kept in a small model array
`timescale 1ns/10ps
module tb_top import bsw_pkg::*; ;
  logic clk;
  logic resetn;
  bsw_sfr_req_t sfr;
  bsw_cmp_t cmp;
  logic sag_event, bat_adc_ready, dcin_adc_ready;
  logic [7:0] bat_adc_data, sfr_rdata, rd_v, a, d;
  logic rail_on_main, dcin_adc_convert, mon_irq;
  int err_total = 0;
  int cmp_count = 0;
  int n;
  // Model of the plain storage registers
  logic [7:0] mreg [logic [7:0]];
  // Reset readback list, last entry unmapped
  logic [7:0] ra [11];

  // Design under test with short delays
  bsw_switchover #(.DCIN_WAIT_CYC(24'h14), .RESTORE_WAIT_CYC(24'h28),
    .BG_PERIOD_CYC(24'h32)) uut (.clk(clk), .resetn(resetn), .sfr(sfr), .cmp(cmp),
    .sag_event(sag_event), .bat_adc_ready(bat_adc_ready), .bat_adc_data(bat_adc_data),
    .dcin_adc_ready(dcin_adc_ready), .sfr_rdata(sfr_rdata), .rail_on_main(rail_on_main),
    .dcin_adc_convert(dcin_adc_convert), .mon_irq(mon_irq));

  // Core side
  bsw_core_model core (.clk(clk), .sfr(sfr), .sfr_rdata(sfr_rdata), .mon_irq(mon_irq));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Verdict and end of run
  task automatic results;
    $display("counts: mismatches %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  // Compare one value
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // Read a register and compare
  task automatic rchk(input logic [7:0] ad, input logic [7:0] e);
    core.rd(ad, rd_v);
    chk($sformatf("reg %h", ad), e, rd_v);
  endtask : rchk

  // Wait for the rail to reach a level, within a cycle window
  task automatic wait_rail(input logic v, input int lo, input int hi);
    n = 0;
    while (rail_on_main !== v && n <= hi) begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp_count++;
    if (n < lo || n > hi) begin
      err_total++;
      $display("BAD rail delay exp %0d..%0d got %0d", lo, hi, n);
      if (n > hi) results();
    end
  endtask : wait_rail

  // Rail must not move for a number of cycles
  task automatic hold_rail(input logic v, input int cyc);
    logic bad;
    bad = 1'b0;
    repeat (cyc) begin
      @(posedge clk);
      #1;
      if (rail_on_main !== v) bad = 1'b1;
    end
    // Hand back on an edge so the caller drives inputs there
    @(posedge clk);
    chk("rail hold", 8'h00, {7'h00, bad});
  endtask : hold_rail

  // Interrupt level a few cycles after its cause
  task automatic irq_is(input logic v);
    repeat (3) @(posedge clk);
    #1;
    chk("mon_irq", {7'h00, v}, {7'h00, mon_irq});
  endtask : irq_is

  // One-cycle event pulse: 0 sag, 1 battery sample, 2 dc input sample
  task automatic pulse_ev(input int k, input logic [7:0] dt);
    @(posedge clk);
    if (k == 0) sag_event <= 1'b1;
    if (k == 1) bat_adc_ready <= 1'b1;
    if (k == 2) dcin_adc_ready <= 1'b1;
    bat_adc_data <= dt;
    @(posedge clk);
    sag_event <= 1'b0;
    bat_adc_ready <= 1'b0;
    dcin_adc_ready <= 1'b0;
  endtask : pulse_ev

  // Cycles until the next conversion request
  task automatic wait_conv(input int hi);
    n = 0;
    while (n <= hi) begin
      @(posedge clk);
      #1;
      n++;
      if (dcin_adc_convert === 1'b1) break;
    end
    // A missing pulse is a mismatch and ends the run
    if (dcin_adc_convert !== 1'b1) begin
      err_total++;
      $display("BAD conversion exp pulse got none");
      results();
    end
  endtask : wait_conv

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("BAD run length exp finish got timeout");
    results();
  end

  // Main sequence
  initial begin
    resetn = 1'b0;
    cmp = 3'b111;
    {sag_event, bat_adc_ready, dcin_adc_ready} = 3'b000;
    bat_adc_data = 8'h00;
    ra = '{8'hA9, 8'hD8, 8'hDF, 8'hEC, 8'hF3, 8'hF4, 8'hF5, 8'hF8, 8'hFA, 8'hFF, 8'h00};
    d = 8'($urandom(32'hD9E5552F));
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    // Reset values, rail still on battery
    // Dc low flag latches while the filter still shows its reset view
    foreach (ra[i]) rchk(ra[i], (ra[i] == BSW_ADDR_FLAGS) ? 8'h10 : 8'h00);
    wait_rail(1'b1, 0, 60);
    rchk(BSW_ADDR_FLAGS, 8'h18);
    rchk(BSW_ADDR_PER_CFG, 8'h40);
    core.wr(BSW_ADDR_FLAGS, 8'h00);
    rchk(BSW_ADDR_FLAGS, 8'h00);
    // Read-only places keep their value
    pulse_ev(1, 8'hFF);
    core.wr(BSW_ADDR_BAT_ADC, 8'h00);
    rchk(BSW_ADDR_BAT_ADC, 8'hFF);
    core.wr(BSW_ADDR_PER_CFG, 8'h00);
    rchk(BSW_ADDR_PER_CFG, 8'h40);
    // Random storage traffic against the model
    mreg[8'hF3] = 8'h00;
    mreg[8'hFA] = 8'h00;
    for (int i = 0; i < 8; i++) begin
      a = ($urandom % 2) ? BSW_ADDR_DELTA : BSW_ADDR_BAT_TH;
      d = 8'($urandom);
      core.wr(a, d);
      mreg[a] = d;
      rchk(BSW_ADDR_DELTA, mreg[8'hF3]);
      rchk(BSW_ADDR_BAT_TH, mreg[8'hFA]);
    end
    core.wr(8'h01, 8'h5A);
    rchk(8'h01, 8'h00);
    // Battery sample: new value, then a value under threshold that keeps setting
    core.wr(BSW_ADDR_BAT_TH, 8'h80);
    core.wr(BSW_ADDR_FLAGS, 8'h00);
    pulse_ev(1, 8'h90);
    rchk(BSW_ADDR_FLAGS, 8'h02);
    core.wr(BSW_ADDR_FLAGS, 8'h00);
    rchk(BSW_ADDR_FLAGS, 8'h00);
    pulse_ev(1, 8'h10);
    core.wr(BSW_ADDR_FLAGS, 8'h00);
    rchk(BSW_ADDR_FLAGS, 8'h02);
    pulse_ev(1, 8'hFF);
    core.wr(BSW_ADDR_FLAGS, 8'h00);
    // Sag and dc input measurement events
    pulse_ev(0, 8'hFF);
    rchk(BSW_ADDR_FLAGS, 8'h20);
    core.wr(BSW_ADDR_FLAGS, 8'h00);
    pulse_ev(2, 8'hFF);
    rchk(BSW_ADDR_FLAGS, 8'h01);
    core.wr(BSW_ADDR_FLAGS, 8'h00);
    // Background conversions, then one on demand
    wait_conv(60);
    wait_conv(60);
    chk("bg period", 8'd50, 8'(n));
    core.wr(BSW_ADDR_ADC_START, 8'h01);
    // The pulse stands for one cycle only, look while it is there
    #1;
    chk("start pulse", 8'h01, {7'h00, dcin_adc_convert});
    // Main supply loss with interrupt masked, then unmasked, then cleared
    core.wr(BSW_ADDR_IRQ_EN, 8'h04);
    @(posedge clk);
    cmp.vdd_ok <= 1'b0;
    wait_rail(1'b0, 0, 6);
    rchk(BSW_ADDR_PER_CFG, 8'h00);
    rchk(BSW_ADDR_FLAGS, 8'h04);
    irq_is(1'b0);
    core.wr(BSW_ADDR_CORE_EN, 8'h02);
    irq_is(1'b1);
    core.wr(BSW_ADDR_FLAGS, 8'h00);
    irq_is(1'b0);
    // Restore with a dropout that restarts the wait
    core.wr(BSW_ADDR_IRQ_EN, 8'h08);
    @(posedge clk);
    cmp.vdd_ok <= 1'b1;
    hold_rail(1'b0, 20);
    cmp.vdd_ok <= 1'b0;
    repeat (6) @(posedge clk);
    cmp.vdd_ok <= 1'b1;
    wait_rail(1'b1, 40, 46);
    irq_is(1'b1);
    core.wr(BSW_ADDR_FLAGS, 8'h00);
    core.wr(BSW_ADDR_IRQ_EN, 8'h00);
    // Dc input as source: delayed trip, restore needs it back
    core.wr(BSW_ADDR_SWO_CFG, 8'h01);
    @(posedge clk);
    cmp.dcin_ok <= 1'b0;
    wait_rail(1'b0, 20, 26);
    rchk(BSW_ADDR_FLAGS, 8'h14);
    hold_rail(1'b0, 60);
    cmp.dcin_ok <= 1'b1;
    wait_rail(1'b1, 40, 46);
    rchk(BSW_ADDR_FLAGS, 8'h1C);
    core.wr(BSW_ADDR_FLAGS, 8'h00);
    core.wr(BSW_ADDR_SWO_CFG, 8'h00);
    // Control pin enabled: falling edge trips, restore waits for it high
    core.wr(BSW_ADDR_PIN_CFG, 8'h10);
    @(posedge clk);
    cmp.bat_ctrl <= 1'b0;
    wait_rail(1'b0, 0, 6);
    rchk(BSW_ADDR_FLAGS, 8'h04);
    hold_rail(1'b0, 60);
    cmp.bat_ctrl <= 1'b1;
    wait_rail(1'b1, 40, 47);
    // One rise for the switchover, one for the restore
    chk("irq rises", 8'h02, 8'(core.irq_rises));
    results();
  end
endmodule : tb_top
